// ### design/sip_defines.svh
/*
  Constants of the synthesizer programming target: byte layout,
  register indices, reset values, test mode and reference codes.
  Assumes inclusion by the design files that use its constants.
*/
`ifndef SIP_DEFINES_SVH
`define SIP_DEFINES_SVH

// ==========================================
// Address byte and byte framing
`define SIP_ADDR_FIXED     5'h18
`define SIP_BYTE_LAST_BIT  3'h7
`define SIP_ROUTE_BIT      7

// ==========================================
// Register indices in auto-increment order
`define SIP_IDX_DIV_HIGH   2'h0
`define SIP_IDX_DIV_LOW    2'h1
`define SIP_IDX_CTRL_ONE   2'h2
`define SIP_IDX_CTRL_TWO   2'h3

// ==========================================
// Field positions
`define SIP_TM_MSB         6
`define SIP_TM_LSB         4
`define SIP_REF_MSB        3
`define SIP_REF_LSB        1
`define SIP_PUMP_MSB       7
`define SIP_PUMP_LSB       6

// ==========================================
// Reset values
`define SIP_DIV_HIGH_RESET 8'h00
`define SIP_DIV_LOW_RESET  8'h00
`define SIP_CTRL_ONE_RESET 8'h90
`define SIP_CTRL_TWO_RESET 8'h00
`define SIP_RATIO_RESET    15'h0000

// ==========================================
// Test mode codes
`define SIP_TM_NORMAL      3'h0
`define SIP_TM_POR_SINK    3'h1
`define SIP_TM_HALF_DIV    3'h2
`define SIP_TM_SINK        3'h3
`define SIP_TM_NORMAL_XTAL 3'h4
`define SIP_TM_DBL_REF     3'h5
`define SIP_TM_OFF         3'h6
`define SIP_TM_SOURCE      3'h7

// ==========================================
// Reference codes and ratios
`define SIP_REF_CODE_2     3'h0
`define SIP_REF_CODE_4     3'h1
`define SIP_REF_CODE_8     3'h2
`define SIP_REF_CODE_16    3'h5
`define SIP_REF_CODE_32    3'h7
`define SIP_REF_RATIO_2    6'h02
`define SIP_REF_RATIO_4    6'h04
`define SIP_REF_RATIO_8    6'h08
`define SIP_REF_RATIO_16   6'h10
`define SIP_REF_RATIO_32   6'h20
`endif

// ### design/sip_pkg.sv
/*
  Types of the synthesizer programming target.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sip_pkg;
  // Bus target states
  typedef enum logic [2:0] {
    BUS_IDLE,
    ADDR_BITS,
    ADDR_ACK,
    DATA_BITS,
    DATA_ACK,
    BUS_IGNORE
  } sip_bus_state_t;

  // Four programming registers
  typedef struct packed {
    logic [7:0] divHigh;
    logic [7:0] divLow;
    logic [7:0] ctrlOne;
    logic [7:0] ctrlTwo;
  } sip_prog_regs_t;

  // Charge pump drive
  typedef struct packed {
    logic up;
    logic down;
    logic enable;
  } sip_pump_t;

  // Decoded operating mode
  typedef struct packed {
    logic tuneRelease;
    logic forceSink;
    logic forceSource;
    logic forceOff;
    logic xtalOut;
    logic halfDivOut;
    logic dblRefOut;
  } sip_mode_t;

  // Whole state of the top module
  typedef struct packed {
    sip_bus_state_t state;
    logic [2:0]     bitCount;
    logic [7:0]     shift;
    logic [1:0]     index;
    logic           indexValid;
    logic           firstData;
    logic           pdHighPending;
    logic           ackOe;
    logic [14:0]    ratio;
    sip_prog_regs_t regs;
    logic           pfdUp;
    logic           pfdDown;
    sip_pump_t      pump;
    logic           tuneRelease;
    logic           xtalBuf;
    logic           halfDivToggle;
  } sip_top_state_t;
endpackage

// ### design/sip_pin_sync.sv
/*
  Two-stage synchroniser with edge pulses for a group of pins.
  Assumes the pins are asynchronous to clock.
*/
`timescale 1ns/1ps
module sip_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Raw pins
  input  wire logic [WIDTH-1:0] pinIn,
  // Synchronised view
  output logic [WIDTH-1:0]      level,
  output logic [WIDTH-1:0]      rise,
  output logic [WIDTH-1:0]      fall
);
  // ==========================================
  // State
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] prev;
  } sip_sync_state_t;

  sip_sync_state_t state_reg;   // Registered state
  sip_sync_state_t state_next;  // Next state

  // Shift pins through the two stages
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = pinIn;
    state_next.stage2 = state_reg.stage1;
    state_next.prev   = state_reg.stage2;
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      // Idle-high bus level, so no false edge follows release
      state_reg <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs read the second stage and its one-cycle delayed copy
  assign level = state_reg.stage2;
  assign rise  = state_reg.stage2 & ~state_reg.prev;
  assign fall  = ~state_reg.stage2 & state_reg.prev;
endmodule

// ### design/sip_rate_divider.sv
/*
  Programmable divider of a step pulse stream.
  Assumes step is a one-cycle pulse on clock.
*/
`timescale 1ns/1ps
module sip_rate_divider #(
  parameter int WIDTH = 15
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Input steps and ratio
  input  wire logic             step,
  input  wire logic [WIDTH-1:0] ratio,
  // Divided pulses
  output logic                  tick,
  output logic                  halfTick
);
  // ==========================================
  // State
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             tick;
    logic             halfTick;
  } sip_div_state_t;

  sip_div_state_t   state_reg;   // Registered state
  sip_div_state_t   state_next;  // Next state
  logic [WIDTH:0]   countPlus;   // Count after this step
  logic             lastStep;    // Step that closes a period

  assign countPlus = {1'b0, state_reg.count} + (WIDTH+1)'(1);
  assign lastStep  = countPlus >= {1'b0, ratio};

  // Count steps, wrap at ratio; ratio 0 or 1 ticks each step
  always_comb begin
    state_next          = state_reg;
    state_next.tick     = 1'b0;
    state_next.halfTick = 1'b0;
    if (step) begin
      if (lastStep) begin
        state_next.count = '0;
        state_next.tick  = 1'b1;
      end else begin
        state_next.count = countPlus[WIDTH-1:0];
      end
      // Mid-period pulse
      if (state_reg.count == (ratio >> 1)) begin
        state_next.halfTick = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick     = state_reg.tick;
  assign halfTick = state_reg.halfTick;
endmodule

// ### design/sip_synth_target.sv
/*
  Two-wire write target loading the synthesizer programming bytes,
  plus the divider, reference and charge pump control they steer.
  Assumes the bus controller, crystal and oscillator are pins
  asynchronous to clock, and an open-drain resolver outside.
*/
`timescale 1ns/1ps
`include "sip_defines.svh"
module sip_synth_target (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Two-wire bus
  input  wire logic          sclIn,
  input  wire logic          sdaIn,
  output logic               sdaOut,
  output logic               sdaOe,
  // Address strap
  input  wire logic [1:0]    addrSelectPin,
  // Timing sources
  input  wire logic          crystalInputOne,
  input  wire logic          oscillatorIn,
  // Loop control
  output sip_pkg::sip_pump_t pumpOutput,
  output logic [1:0]         pumpCurrentSelect,
  output logic               tuningRelease,
  output logic               crystalBufferOutput,
  output logic [14:0]        dividerRatio
);
  // ==========================================
  // Decoding functions
  // Address byte matches fixed bits, strap, write direction
  function automatic logic addrMatch(input logic [7:0] b, input logic [1:0] sel);
    addrMatch = (b[7:3] == `SIP_ADDR_FIXED) && (b[2:1] == sel) && !b[0];
  endfunction

  function automatic logic [5:0] refRatioOf(input logic [2:0] code);
    unique case (code)
      `SIP_REF_CODE_4:  refRatioOf = `SIP_REF_RATIO_4;
      `SIP_REF_CODE_8:  refRatioOf = `SIP_REF_RATIO_8;
      `SIP_REF_CODE_16: refRatioOf = `SIP_REF_RATIO_16;
      `SIP_REF_CODE_32: refRatioOf = `SIP_REF_RATIO_32;
      default:          refRatioOf = `SIP_REF_RATIO_2;  // Code 000 and unusable codes
    endcase
  endfunction

  function automatic sip_pkg::sip_mode_t modeOf(input logic [2:0] tm);
    modeOf             = '0;
    modeOf.tuneRelease = 1'b1;
    unique case (tm)
      `SIP_TM_NORMAL:      modeOf.tuneRelease = 1'b0;
      `SIP_TM_NORMAL_XTAL: begin
        modeOf.tuneRelease = 1'b0;
        modeOf.xtalOut     = 1'b1;
      end
      `SIP_TM_POR_SINK, `SIP_TM_SINK: begin
        modeOf.forceSink = 1'b1;
        modeOf.xtalOut   = 1'b1;
      end
      `SIP_TM_SOURCE: begin
        modeOf.forceSource = 1'b1;
        modeOf.xtalOut     = 1'b1;
      end
      `SIP_TM_OFF: begin
        modeOf.forceOff = 1'b1;
        modeOf.xtalOut  = 1'b1;
      end
      `SIP_TM_HALF_DIV: begin
        modeOf.forceOff   = 1'b1;
        modeOf.halfDivOut = 1'b1;
      end
      `SIP_TM_DBL_REF: begin
        modeOf.forceOff  = 1'b1;
        modeOf.dblRefOut = 1'b1;
      end
    endcase
  endfunction

  // ==========================================
  // Pin synchronisation
  logic [5:0] pinLevel;  // Synced levels
  logic [5:0] pinRise;   // Rising pulses
  logic [5:0] pinFall;   // Falling pulses

  sip_pin_sync #(
    .WIDTH (6)
  ) pinSync (
    .clock (clock),
    .rst   (rst),
    .pinIn ({oscillatorIn, crystalInputOne, addrSelectPin, sdaIn, sclIn}),
    .level (pinLevel),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  logic       sclRise;      // Bus clock rising
  logic       sclFall;      // Bus clock falling
  logic       sdaLevel;     // Bus data level
  logic       busStart;     // START seen
  logic       busStop;      // STOP seen
  logic [1:0] addrSel;      // Strap address bits
  logic       crystalLevel; // Crystal level
  logic       crystalRise;  // Crystal edge
  logic       oscRise;      // Oscillator edge

  assign sclRise      = pinRise[0];
  assign sclFall      = pinFall[0];
  assign sdaLevel     = pinLevel[1];
  assign busStart     = pinFall[1] && pinLevel[0];
  assign busStop      = pinRise[1] && pinLevel[0];
  assign addrSel      = pinLevel[3:2];
  assign crystalLevel = pinLevel[4];
  assign crystalRise  = pinRise[4];
  assign oscRise      = pinRise[5];

  // ==========================================
  // State and loop dividers
  sip_pkg::sip_top_state_t state_reg;   // Registered state
  sip_pkg::sip_top_state_t state_next;  // Next state
  sip_pkg::sip_mode_t      mode;        // Current mode
  logic [7:0]              newByte;     // Byte with this bit
  logic                    byteDone;    // Eighth rising edge
  logic                    dataDone;    // Eighth edge of data
  logic [1:0]              dataIdx;     // Target of data byte
  logic                    dividedOscTick;   // Divided oscillator
  logic                    comparisonTick;   // Comparison pulse
  logic                    comparisonHalf;   // Mid-period pulse

  assign newByte  = {state_reg.shift[6:0], sdaLevel};
  assign byteDone = sclRise && !busStart && !busStop && (state_reg.bitCount == `SIP_BYTE_LAST_BIT);
  assign dataDone = byteDone && (state_reg.state == sip_pkg::DATA_BITS);
  assign dataIdx  = state_reg.firstData ?
                    (newByte[`SIP_ROUTE_BIT] ? `SIP_IDX_CTRL_ONE : `SIP_IDX_DIV_HIGH) : state_reg.index;
  assign mode     = modeOf(state_reg.regs.ctrlOne[`SIP_TM_MSB:`SIP_TM_LSB]);

  sip_rate_divider #(
    .WIDTH (15)
  ) mainDivider (
    .clock    (clock),
    .rst      (rst),
    .step     (oscRise),
    .ratio    (state_reg.ratio),
    .tick     (dividedOscTick),
    .halfTick ()
  );

  sip_rate_divider #(
    .WIDTH (6)
  ) refDivider (
    .clock    (clock),
    .rst      (rst),
    .step     (crystalRise),
    .ratio    (refRatioOf(state_reg.regs.ctrlOne[`SIP_REF_MSB:`SIP_REF_LSB])),
    .tick     (comparisonTick),
    .halfTick (comparisonHalf)
  );

  // ==========================================
  // Bus target and loop control
  always_comb begin
    logic up;
    logic down;
    up         = state_reg.pfdUp | comparisonTick;
    down       = state_reg.pfdDown | dividedOscTick;
    state_next = state_reg;
    if (busStart) begin
      // Any START opens a new address byte
      state_next.state     = sip_pkg::ADDR_BITS;
      state_next.bitCount  = 3'h0;
      state_next.ackOe     = 1'b0;
      state_next.firstData = 1'b1;
    end else if (busStop) begin
      state_next.state = sip_pkg::BUS_IDLE;
      state_next.ackOe = 1'b0;
      // high byte alone applies at STOP
      if (state_reg.pdHighPending) begin
        state_next.ratio         = {state_reg.regs.divHigh[6:0], state_reg.regs.divLow};
        state_next.pdHighPending = 1'b0;
      end
    end else begin
      unique case (state_reg.state)
        sip_pkg::BUS_IDLE, sip_pkg::BUS_IGNORE: begin
          state_next.ackOe = 1'b0;
        end
        sip_pkg::ADDR_BITS: begin
          if (sclRise) begin
            state_next.shift    = newByte;
            state_next.bitCount = state_reg.bitCount + 3'h1;
          end
          if (byteDone) begin
            state_next.state = addrMatch(newByte, addrSel) ? sip_pkg::ADDR_ACK : sip_pkg::BUS_IGNORE;
          end
        end
        sip_pkg::ADDR_ACK, sip_pkg::DATA_ACK: begin
          // Drive low for one bus clock period
          if (sclFall) begin
            state_next.ackOe = !state_reg.ackOe;
            if (state_reg.ackOe) begin
              state_next.state = sip_pkg::DATA_BITS;
            end
          end
        end
        sip_pkg::DATA_BITS: begin
          if (sclRise) begin
            state_next.shift    = newByte;
            state_next.bitCount = state_reg.bitCount + 3'h1;
          end
          if (dataDone) begin
            state_next.state     = sip_pkg::DATA_ACK;
            state_next.firstData = 1'b0;
            state_next.index      = dataIdx + 2'h1;
            state_next.indexValid = (state_reg.firstData || state_reg.indexValid) && (dataIdx != `SIP_IDX_CTRL_TWO);
            if (state_reg.firstData || state_reg.indexValid) begin
              unique case (dataIdx)
                `SIP_IDX_DIV_HIGH: begin
                  state_next.regs.divHigh  = newByte;
                  state_next.pdHighPending = 1'b1;
                end
                `SIP_IDX_DIV_LOW: begin
                  state_next.regs.divLow   = newByte;
                  state_next.ratio         = {state_reg.regs.divHigh[6:0], newByte};
                  state_next.pdHighPending = 1'b0;
                end
                `SIP_IDX_CTRL_ONE: state_next.regs.ctrlOne = {newByte[7:1], 1'b0};
                `SIP_IDX_CTRL_TWO: state_next.regs.ctrlTwo = {newByte[7:6], 6'h00};
              endcase
            end
          end
        end
      endcase
    end
    state_next.pfdUp   = up && !down;
    state_next.pfdDown = down && !up;
    state_next.pump.up     = state_reg.pfdUp;
    state_next.pump.down   = state_reg.pfdDown;
    state_next.pump.enable = 1'b1;
    if (mode.forceSink || mode.forceSource || mode.forceOff) begin
      state_next.pump.up     = mode.forceSource;
      state_next.pump.down   = mode.forceSink;
      state_next.pump.enable = !mode.forceOff;
    end
    state_next.tuneRelease = mode.tuneRelease;
    // Crystal buffer and monitor outputs
    if (dividedOscTick) begin
      state_next.halfDivToggle = !state_reg.halfDivToggle;
    end
    state_next.xtalBuf = (mode.xtalOut && crystalLevel) ||
                         (mode.halfDivOut && state_reg.halfDivToggle) ||
                         (mode.dblRefOut && (comparisonTick || comparisonHalf));
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg              <= '0;
      state_reg.state        <= sip_pkg::BUS_IDLE;
      state_reg.regs.divHigh <= `SIP_DIV_HIGH_RESET;
      state_reg.regs.divLow  <= `SIP_DIV_LOW_RESET;
      state_reg.regs.ctrlOne <= `SIP_CTRL_ONE_RESET;
      state_reg.regs.ctrlTwo <= `SIP_CTRL_TWO_RESET;
      state_reg.ratio        <= `SIP_RATIO_RESET;
      state_reg.tuneRelease  <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Outputs
  assign sdaOut              = 1'b0;
  assign sdaOe               = state_reg.ackOe;
  assign pumpOutput          = state_reg.pump;
  assign pumpCurrentSelect   = state_reg.regs.ctrlTwo[`SIP_PUMP_MSB:`SIP_PUMP_LSB];
  assign tuningRelease       = state_reg.tuneRelease;
  assign crystalBufferOutput = state_reg.xtalBuf;
  assign dividerRatio        = state_reg.ratio;

  // ==========================================
  // Checks
  chk_addr_write_only: assert property (@(posedge clock) disable iff (rst)
    state_reg.state == sip_pkg::ADDR_ACK |-> !state_reg.shift[0])
    else $error("acknowledge given to a read address");

  chk_addr_match_ack: assert property (@(posedge clock) disable iff (rst)
    state_reg.state == sip_pkg::ADDR_ACK |-> state_reg.shift[7:1] == {`SIP_ADDR_FIXED, addrSel})
    else $error("acknowledge given to a foreign address");

  chk_ack_only_slot: assert property (@(posedge clock) disable iff (rst)
    $rose(sdaOe) |-> $past(sclFall) && (state_reg.state inside {sip_pkg::ADDR_ACK, sip_pkg::DATA_ACK}))
    else $error("data line driven outside an acknowledge slot");

  chk_route_high: assert property (@(posedge clock) disable iff (rst)
    dataDone && state_reg.firstData && !newByte[7] |=> state_reg.regs.divHigh == $past(newByte))
    else $error("first byte with MSB zero not stored as divider high");

  chk_route_ctrl: assert property (@(posedge clock) disable iff (rst)
    dataDone && state_reg.firstData && newByte[7] |=> state_reg.regs.ctrlOne[7:1] == $past(newByte[7:1]))
    else $error("first byte with MSB one not stored as control one");

  chk_auto_increment: assert property (@(posedge clock) disable iff (rst)
    dataDone && !state_reg.firstData && state_reg.indexValid |=> state_reg.index == $past(state_reg.index) + 2'h1)
    else $error("register index did not advance");

  chk_high_waits: assert property (@(posedge clock) disable iff (rst)
    dataDone && (state_reg.firstData || state_reg.indexValid) && dataIdx == `SIP_IDX_DIV_HIGH
    |=> $stable(state_reg.ratio) && state_reg.pdHighPending)
    else $error("divider ratio changed on the high byte");

  chk_low_applies: assert property (@(posedge clock) disable iff (rst)
    dataDone && !state_reg.firstData && state_reg.indexValid && dataIdx == `SIP_IDX_DIV_LOW
    |=> dividerRatio[7:0] == $past(newByte) ##1 dividerRatio[7:0] == $past(newByte, 2))
    else $error("divider ratio not applied after the low byte");

  chk_stop_applies: assert property (@(posedge clock) disable iff (rst)
    busStop && state_reg.pdHighPending |=> dividerRatio[14:8] == $past(state_reg.regs.divHigh[6:0]))
    else $error("pending high byte not applied at STOP");

  chk_pump_sink: assert property (@(posedge clock) disable iff (rst)
    mode.forceSink |=> pumpOutput.down && !pumpOutput.up && pumpOutput.enable && tuningRelease)
    else $error("sink test mode did not force the pump");

  chk_pfd_exclusive: assert property (@(posedge clock) disable iff (rst)
    !mode.tuneRelease |=> !(pumpOutput.up && pumpOutput.down))
    else $error("pump driven up and down together");
endmodule

// ### sim/sip_bus_ctrl_model.sv
/*
  Two-wire bus controller model that sends write frames.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps
module sip_bus_ctrl_model (
  // Clock
  input  wire logic clock,
  // Bus
  input  wire logic sdaWire,
  output logic      sclLine,
  output logic      sdaDrive
);
  // ==========
  // Idle bus
  initial begin
    sclLine = 1'b1;
    sdaDrive = 1'b1;
  end

  // Wait falling edges
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask

  // START, data falls while clock high
  task automatic startCond();
    sdaDrive = 1'b1;
    hold(4);
    sclLine = 1'b1;
    hold(6);
    sdaDrive = 1'b0;
    hold(6);
    sclLine = 1'b0;
    hold(4);
  endtask

  // One bit, wire sampled while clock high
  task automatic putBit(input logic b, output logic s);
    sdaDrive = b;
    hold(6);
    sclLine = 1'b1;
    hold(8);
    s = sdaWire;
    sclLine = 1'b0;
    hold(4);
  endtask

  // Byte MSB first, then released ninth bit
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      putBit(b[i], s);
    end
    putBit(1'b1, s);
    ack = ~s;
  endtask

  // STOP, data rises while clock high
  task automatic stopCond();
    sdaDrive = 1'b0;
    hold(4);
    sclLine = 1'b1;
    hold(6);
    sdaDrive = 1'b1;
    hold(6);
  endtask
endmodule

// ### sim/testbench.sv
/*
  Self-checking bench of the programming target.
  Assumes the bus controller model and open-drain wire resolution here.
*/
`timescale 1ns/1ps
module testbench;
  // ==========
  // Frame rows
  typedef struct packed {
    logic [1:0]      strap;
    logic [7:0]      addr;
    logic [2:0]      n;
    logic [0:4][7:0] data;
    logic            ack;
    logic [14:0]     ratio;
    logic [1:0]      pump;
    logic            tune;
  } sip_tb_row_t;
  logic        clock, rst, xtal, osc, ack, a;
  logic [1:0]  strap;
  logic        sclLine, sdaDrive, sdaOe, sdaOut, tuneRel;
  logic [1:0]  pumpSel;
  logic [2:0]  pumpOut;
  logic        xtalBuf;
  logic [14:0] ratio;
  int          num_errors, checks_done;
  sip_tb_row_t rows [7];
  // Open-drain data wire with pull-up
  wire logic   sdaWire = sdaDrive & (sdaOe ? sdaOut : 1'b1);

  sip_synth_target u_sip_synth_target (.clock(clock), .rst(rst), .sclIn(sclLine), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectPin(strap), .crystalInputOne(xtal), .oscillatorIn(osc),
    .pumpOutput(pumpOut), .pumpCurrentSelect(pumpSel), .tuningRelease(tuneRel), .crystalBufferOutput(xtalBuf),
    .dividerRatio(ratio));
  sip_bus_ctrl_model u_sip_bus_ctrl_model (.clock(clock), .sdaWire(sdaWire), .sclLine(sclLine),
    .sdaDrive(sdaDrive));

  // Clock and timing sources
  initial begin
    xtal = 1'b0;
    osc = 1'b0;
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(negedge clock) begin
    xtal <= ~xtal;
    osc <= xtal ? ~osc : osc;
  end

  // Value compare
  task automatic checkVal(input logic [14:0] got, input logic [14:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Verdict
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    end_sim();
  end

  // ==========
  // Main sequence
  initial begin
    {strap, num_errors, checks_done} = '0;
    rst = 1'b1;
    rows[0] = {2'h0, 8'hc0, 3'h2, 40'h1234000000, 1'b1, 15'h1234, 2'h0, 1'b1};
    rows[1] = {2'h0, 8'hc0, 3'h2, 40'h80c0000000, 1'b1, 15'h1234, 2'h3, 1'b0};
    rows[2] = {2'h0, 8'hc0, 3'h5, 40'h05678040ff, 1'b1, 15'h0567, 2'h1, 1'b0};
    rows[3] = {2'h0, 8'hc0, 3'h1, 40'hb000000000, 1'b1, 15'h0567, 2'h1, 1'b1};
    rows[4] = {2'h0, 8'hc2, 3'h1, 40'h1200000000, 1'b0, 15'h0567, 2'h1, 1'b1};
    rows[5] = {2'h0, 8'hc1, 3'h1, 40'h8000000000, 1'b0, 15'h0567, 2'h1, 1'b1};
    rows[6] = {2'h2, 8'hc4, 3'h1, 40'h8000000000, 1'b1, 15'h0567, 2'h1, 1'b0};
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    checkVal(ratio, 15'h0000);
    checkVal(tuneRel, 1'b1);
    checkVal(sdaOe, 1'b0);
    // Ordinary frames
    foreach (rows[r]) begin
      strap = rows[r].strap;
      u_sip_bus_ctrl_model.hold(4);
      u_sip_bus_ctrl_model.startCond();
      u_sip_bus_ctrl_model.sendByte(rows[r].addr, ack);
      checkVal(ack, rows[r].ack);
      for (int j = 0; j < rows[r].n; j++) begin
        u_sip_bus_ctrl_model.sendByte(rows[r].data[j], a);
        checkVal(a, rows[r].ack);
      end
      u_sip_bus_ctrl_model.stopCond();
      checkVal(ratio, rows[r].ratio);
      checkVal(pumpSel, rows[r].pump);
      checkVal(tuneRel, rows[r].tune);
      // Sink modes force the pump; normal mode enables it, buffer off
      if (rows[r].tune) checkVal(pumpOut, 15'h3);
      else checkVal({pumpOut[0], xtalBuf}, 15'h2);
    end
    // High byte alone waits for STOP
    u_sip_bus_ctrl_model.startCond();
    u_sip_bus_ctrl_model.sendByte(8'hc4, a);
    u_sip_bus_ctrl_model.sendByte(8'h7f, a);
    checkVal(ratio, 15'h0567);
    u_sip_bus_ctrl_model.stopCond();
    u_sip_bus_ctrl_model.hold(4);
    checkVal(ratio, 15'h7f67);
    checkVal(pumpSel, 2'h1);
    // Forced pump: off, then source after a repeated START
    u_sip_bus_ctrl_model.startCond();
    u_sip_bus_ctrl_model.sendByte(8'hc4, a);
    u_sip_bus_ctrl_model.sendByte(8'he0, a);
    checkVal(pumpOut, 15'h0);
    u_sip_bus_ctrl_model.startCond();
    u_sip_bus_ctrl_model.sendByte(8'hc4, a);
    u_sip_bus_ctrl_model.sendByte(8'hff, a);
    checkVal(pumpOut, 15'h5);
    checkVal(tuneRel, 1'b1);
    checkVal(ratio, 15'h7f67);
    u_sip_bus_ctrl_model.stopCond();
    // Second reset in mid-run
    rst = 1'b1;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    checkVal(ratio, 15'h0000);
    checkVal(pumpSel, 2'h0);
    checkVal(pumpOut, 15'h3);
    end_sim();
  end
endmodule
